// ---- design/aphp_pkg.sv ----
// Package for the parallel host port of the sampling converter.
// Assumes one 40 MHz system clock; host pins arrive asynchronously.
package aphp_pkg;
  localparam int APHP_DATA_W = 13;
  localparam int APHP_NARROW_W = 8;
  localparam int APHP_CFG_SYNC_DIR_BIT = 4;
  localparam int APHP_CFG_BUS_WIDTH_BIT = 3;
  localparam logic [12:0] APHP_CFG_RESET = 13'h0000;
  localparam logic [12:0] APHP_NARROW_MASK = 13'h00FF;
  localparam logic [12:0] APHP_WIDE_MASK = 13'h1FFF;
  // Conversion length in ns, and its count of 25 ns cycles
  localparam int APHP_CLK_PERIOD_NS = 25;
  localparam int APHP_CONV_TIME_NS = 3600;
  localparam int APHP_CONV_CYCLES = APHP_CONV_TIME_NS / APHP_CLK_PERIOD_NS;
  localparam int APHP_CNT_W = 8;
  localparam logic [7:0] APHP_CNT_ONE = 8'h01;
  localparam logic [7:0] APHP_CNT_ZERO = 8'h00;
  typedef enum logic [1:0] {APHP_IDLE, APHP_BUSY, APHP_DONE} aphp_state_t;
endpackage

// ---- design/aphp_sync2.sv ----
// Two-flop synchroniser for one asynchronous level.
// Assumes a single clock and an active-low async reset.
`timescale 1ns/1ps
module aphp_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  // Only the second flop is read outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ---- design/aphp_top.sv ----
// Parallel host port: strobed 13-bit data bus, sync pin, ready output.
// Assumes host pins are asynchronous to clk and the host holds strobes
// for several clk cycles; the converter core is modelled by a counter.
//
// How it works
// - edge select pin sampled once after reset
// - config bit four sets sync pin direction
// - input mode: sync rising edge starts conversion
// - output mode: sync high during conversion
// - config bit three selects 8 or 13 lines
// - line 12 is MSB, line 0 LSB
// - capture data on selected write edge
// - drive data only while read and select low
// - active-low ready pulses for one cycle after conversion end
`timescale 1ns/1ps
module aphp_top
  import aphp_pkg::*;
#(
  parameter int DATA_W = APHP_DATA_W,
  parameter int CONV_CYCLES = APHP_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic write_edge_select_pin,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic rdy_n,
  input wire logic [DATA_W-1:0] result_in,
  output logic [DATA_W-1:0] cfg_word,
  output logic cfg_strobe
);
  logic rst_a_reg, rst_n;
  logic cs_s, rd_s, wr_s, wes_s, sync_s;
  logic wr_act_reg, wes_reg, wes_taken_reg, sync_prev_reg;
  logic [1:0] wes_wait_reg;
  logic [DATA_W-1:0] din_s;
  logic [DATA_W-1:0] cfg_reg;
  logic [APHP_CNT_W-1:0] cnt_reg;
  aphp_state_t state_reg;
  logic wr_act, wr_rise, wr_fall, take, start, done;

  // Reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_a_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n <= rst_a_reg;
    end
  end

  // Pin synchronisers
  aphp_sync2 #(.RESET_VAL(1'b1)) u_cs (.clk(clk), .rst_n(rst_n),
    .d(cs_n), .q(cs_s));
  aphp_sync2 #(.RESET_VAL(1'b1)) u_rd (.clk(clk), .rst_n(rst_n),
    .d(rd_n), .q(rd_s));
  aphp_sync2 #(.RESET_VAL(1'b1)) u_wr (.clk(clk), .rst_n(rst_n),
    .d(wr_n), .q(wr_s));
  aphp_sync2 #(.RESET_VAL(1'b0)) u_wes (.clk(clk), .rst_n(rst_n),
    .d(write_edge_select_pin), .q(wes_s));
  aphp_sync2 #(.RESET_VAL(1'b0)) u_sy (.clk(clk), .rst_n(rst_n),
    .d(sync_in), .q(sync_s));
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_din
      aphp_sync2 #(.RESET_VAL(1'b0)) u_d (.clk(clk), .rst_n(rst_n),
        .d(data_in[gi]), .q(din_s[gi]));
    end
  endgenerate

  // Edge select caught once, after its synchroniser has refilled; the
  // flops hold their reset value for two edges after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wes_reg <= 1'b0;
      wes_taken_reg <= 1'b0;
      wes_wait_reg <= '0;
    end else begin
      wes_wait_reg <= {wes_wait_reg[0], 1'b1};
      if (wes_wait_reg[1] && !wes_taken_reg) begin
        wes_reg <= wes_s;
        wes_taken_reg <= 1'b1;
      end
    end
  end

  // Write window: input buffers live only with write and select low
  assign wr_act = !wr_s && !cs_s;
  assign wr_rise = wr_act_reg && !wr_act;
  assign wr_fall = !wr_act_reg && wr_act;
  assign take = wes_taken_reg && (wes_reg ? wr_fall : wr_rise);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_act_reg <= 1'b0;
    end else begin
      wr_act_reg <= wr_act;
    end
  end

  // Configuration capture, MSB on line 12
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= APHP_CFG_RESET;
      cfg_word <= APHP_CFG_RESET;
      cfg_strobe <= 1'b0;
    end else begin
      cfg_strobe <= take;
      if (take) begin
        cfg_reg <= din_s;
        cfg_word <= din_s;
      end
    end
  end

  // Sync edge detect in input mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_reg <= 1'b0;
    end else begin
      sync_prev_reg <= sync_s;
    end
  end
  assign start = cfg_reg[APHP_CFG_SYNC_DIR_BIT] ?
    (sync_s && !sync_prev_reg) : take;
  assign done = (cnt_reg == APHP_CNT_ONE);

  // Conversion sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= APHP_IDLE;
      cnt_reg <= APHP_CNT_ZERO;
    end else begin
      case (state_reg)
        APHP_IDLE: begin
          if (start) begin
            state_reg <= APHP_BUSY;
            cnt_reg <= APHP_CNT_W'(CONV_CYCLES);
          end
        end
        APHP_BUSY: begin
          cnt_reg <= cnt_reg - APHP_CNT_ONE;
          if (done) begin
            state_reg <= APHP_DONE;
          end
        end
        APHP_DONE: begin
          state_reg <= APHP_IDLE;
        end
        default: begin
          state_reg <= APHP_IDLE;
        end
      endcase
    end
  end

  // Sync pin drive and ready indicator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= 1'b0;
      sync_oe <= 1'b0;
      rdy_n <= 1'b1;
    end else begin
      sync_oe <= !cfg_reg[APHP_CFG_SYNC_DIR_BIT];
      sync_out <= !cfg_reg[APHP_CFG_SYNC_DIR_BIT] &&
        (state_reg == APHP_BUSY) && !done;
      rdy_n <= !(state_reg == APHP_DONE);
    end
  end

  // Read drive with width mask
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= '0;
      data_oe <= '0;
    end else if (!rd_s && !cs_s && !wr_act) begin
      data_out <= result_in;
      data_oe <= cfg_reg[APHP_CFG_BUS_WIDTH_BIT] ?
        APHP_WIDE_MASK : APHP_NARROW_MASK;
    end else begin
      data_oe <= '0;
    end
  end

  ready_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == APHP_DONE) |=> !rdy_n)
    else $error("ready not pulsed after conversion");
  release_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_s || cs_s) |=> (data_oe == '0))
    else $error("data driven without read");
  narrow_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_reg[APHP_CFG_BUS_WIDTH_BIT] |=> (data_oe[12:8] == 5'h00))
    else $error("upper lines driven in narrow mode");
  sync_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_reg[APHP_CFG_SYNC_DIR_BIT] |=> !sync_oe)
    else $error("sync driven in input mode");
  sequence s_start_in;
    (state_reg == APHP_IDLE) && cfg_reg[APHP_CFG_SYNC_DIR_BIT] &&
      sync_s && !sync_prev_reg;
  endsequence
  sync_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_start_in |=> (state_reg == APHP_BUSY))
    else $error("sync edge did not start conversion");
  sync_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == APHP_BUSY && !done && !cfg_reg[APHP_CFG_SYNC_DIR_BIT])
      |=> sync_out)
    else $error("sync not high during conversion");
  edge_take_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wes_taken_reg && !wes_reg && wr_rise) |=> cfg_strobe)
    else $error("rising write edge not captured");
  fall_take_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wes_taken_reg && wes_reg && wr_fall) |=> cfg_strobe)
    else $error("falling write edge not captured");
  edge_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    wes_taken_reg |=> $stable(wes_reg))
    else $error("edge select changed after power-up");
endmodule

// ---- test/aphp_host_model.sv ----
// Host bus model: strobes, write data, sync pulse; data inverted after use.
// Assumes it is driven from falling clock edges by the bench.
`timescale 1ns/1ps
module aphp_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [12:0] data_in,
  output logic sync_in
);
  // Idle bus, data shows a pattern rather than a stale word
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 13'h0AAA;
    sync_in = 1'b0;
  end
  // Write cycle: data held past the closing edge, then inverted
  task automatic bus_write(input logic [12:0] d, input int hold);
    @(negedge clk);
    data_in = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (hold) @(negedge clk);
    wr_n = 1'b1;
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
    data_in = ~d;
  endtask
  // Read window open and close
  task automatic read_open();
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
  endtask
  task automatic read_close();
    @(negedge clk);
    cs_n = 1'b1;
    rd_n = 1'b1;
  endtask
  // Rising edge on the sync pin
  task automatic pulse_sync();
    @(negedge clk);
    sync_in = 1'b1;
    repeat (4) @(negedge clk);
    sync_in = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ---- test/adc_parallel_host_port_bench.sv ----
// Bench for the host port: writes, reads, sync in both directions.
// Assumes a short conversion count and the host model beside the design.
`timescale 1ns/1ps
module adc_parallel_host_port_bench;
  import aphp_pkg::*;
  logic clk;
  logic arst_n;
  logic edge_sel;
  logic [12:0] result;
  logic cs_n, rd_n, wr_n, sync_in, sync_out, sync_oe, rdy_n, cfg_strobe;
  logic [12:0] data_in, data_out, data_oe, cfg_word;
  int mismatches = 0;
  int compares = 0;
  aphp_host_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_in(data_in), .sync_in(sync_in));
  aphp_top #(.CONV_CYCLES(16)) uut (.clk(clk), .arst_n(arst_n),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .write_edge_select_pin(edge_sel),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
    .rdy_n(rdy_n), .result_in(result), .cfg_word(cfg_word),
    .cfg_strobe(cfg_strobe));
  // Free-running 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait: 0 strobe, 1 sync out, 2 ready
  task automatic wait_for(input int sel, input logic lvl);
    int n;
    logic v;
    n = 0;
    v = ~lvl;
    while (v !== lvl && n < 400) begin
      @(negedge clk);
      v = (sel == 0) ? cfg_strobe : (sel == 1) ? sync_out : rdy_n;
      n++;
    end
    if (v !== lvl) begin
      mismatches++;
      wrap_up();
    end
  endtask
  // Reset with the edge select level held from then on
  task automatic s_write(input logic sel, input logic [12:0] word);
    arst_n = 1'b0;
    edge_sel = sel;
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (8) @(negedge clk);
    // Judge the capture and the wr_n level while the write data is still driven, and let
    // the whole cycle end before any other task touches the strobes
    fork
      host.bus_write(word, 12);
      begin
        wait_for(0, 1'b1);
        check({12'h000, wr_n}, {12'h000, ~sel});
        check(cfg_word, word);
      end
    join
    repeat (6) @(negedge clk);
  endtask
  task automatic s_read(input logic [12:0] mask);
    host.read_open();
    repeat (6) @(negedge clk);
    check(data_oe, mask);
    check(data_out & mask, result & mask);
    host.read_close();
    repeat (6) @(negedge clk);
    check(data_oe, 13'h0000);
  endtask
  task automatic s_sync_in();
    check({12'h000, sync_oe}, 13'h0000);
    host.pulse_sync();
    wait_for(2, 1'b0);
  endtask
  task automatic s_out_conv();
    check({12'h000, sync_oe}, 13'h0001);
    check({12'h000, sync_out}, 13'h0001);
    wait_for(2, 1'b0);
    repeat (2) @(negedge clk);
    check({12'h000, sync_out}, 13'h0000);
  endtask
  // Main sequence
  initial begin
    arst_n = 1'b0;
    edge_sel = 1'b0;
    result = 13'h1ABC;
    s_write(1'b1, 13'h0010);
    s_read(APHP_NARROW_MASK);
    s_sync_in();
    s_write(1'b0, 13'h1A48);
    s_out_conv();
    s_read(APHP_WIDE_MASK);
    wrap_up();
  end
endmodule
